// >>> verilog/stb_pkg.sv
// Package with constants and carrier types for the symbol timestamp and backoff unit.
package stb_pkg;
  localparam int          SLOT_SYMBOLS    = 20;
  localparam int          SLOT_TIME_US    = 320;
  localparam int          CLOCK_MHZ       = 10;
  localparam int          SYMBOL_CYCLES   = (SLOT_TIME_US * CLOCK_MHZ) / SLOT_SYMBOLS;
  localparam logic [15:0] NETWORK_ID_ANY  = 16'hFFFF;
  localparam logic [31:0] STAMP_RESET     = 32'h0000_0000;
  localparam int          IRQ_COUNT       = 5;
  localparam int          IRQ_CMP1        = 0;
  localparam int          IRQ_CMP2        = 1;
  localparam int          IRQ_CMP3        = 2;
  localparam int          IRQ_OVERFLOW    = 3;
  localparam int          IRQ_BACKOFF     = 4;
  localparam logic [4:0]  IRQ_RESET       = 5'h00;

  // Frame events from the radio receive path.
  typedef struct packed {
    logic        sfdDone;
    logic        frameEnd;
    logic        fcsValid;
    logic        isBeacon;
    logic [15:0] srcNetworkId;
  } stb_rx_t;

  // Settings of one compare unit.
  typedef struct packed {
    logic        relative;
    logic [31:0] value;
  } stb_cmp_t;
endpackage : stb_pkg

// >>> verilog/stb_backoff.sv
// Backoff slot counter that pulses once every slot while the transceiver clock runs and the radio is awake.
`timescale 1ns/1ns
module stb_backoff #(
  parameter int SYMBOL_CYCLES = stb_pkg::SYMBOL_CYCLES,
  parameter int SLOT_SYMBOLS  = stb_pkg::SLOT_SYMBOLS
) (
  input  wire logic clock,
  input  wire logic arst_n,
  input  wire logic enable,
  input  wire logic restart,
  output logic      slotPulse
);
  initial begin
    if (SYMBOL_CYCLES < 1 || SLOT_SYMBOLS < 1 || SYMBOL_CYCLES > 65535 || SLOT_SYMBOLS > 255) begin
      $error("stb_backoff: counts out of range");
    end
  end

  typedef struct packed {
    logic [15:0] cyc;
    logic [7:0]  sym;
    logic        pulse;
  } stb_bo_state_t;

  stb_bo_state_t state;
  stb_bo_state_t next_state;

  // Counts only while enabled; a stopped clock or sleeping transceiver freezes and clears it.
  always_comb begin
    next_state = state;
    next_state.pulse = 1'b0;
    if (!enable || restart) begin
      next_state.cyc = 16'h0000;
      next_state.sym = 8'h00;
    end else if (state.cyc == 16'(SYMBOL_CYCLES - 1)) begin
      next_state.cyc = 16'h0000;
      if (state.sym == 8'(SLOT_SYMBOLS - 1)) begin
        next_state.sym = 8'h00;
        next_state.pulse = 1'b1;
      end else begin
        next_state.sym = state.sym + 8'h01;
      end
    end else begin
      next_state.cyc = state.cyc + 16'h0001;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign slotPulse = state.pulse;

  a_slot_spacing: assert property (@(posedge clock) disable iff (!arst_n)
    slotPulse |=> !slotPulse) else $error("slot pulse longer than one cycle");
  a_no_pulse_off: assert property (@(posedge clock) disable iff (!arst_n)
    !enable |=> !slotPulse) else $error("slot pulse while disabled");
endmodule : stb_backoff

// >>> verilog/stb_timestamp_unit.sv
// Symbol counter timing events: compares, frame and beacon stamps, backoff slots, flags and wake.
`timescale 1ns/1ns
// Overview of operation
// - A flag clears itself when its interrupt handler is entered.
// - Writing one to a flag bit clears it; zero leaves it.
// - Every counter event raises a wake request, in any sleep state.
// - Backoff counter advances only while the transceiver clock runs.
// - Transceiver off or asleep keeps the backoff counter disabled.
// - Backoff counter interrupts every 20 symbols, that is 320 microseconds.
// - Frame stamp takes the counter value when the delimiter completes.
// - Frame stamp is valid from one receive start to the next.
// - Frame stamps are taken even for frames with bad check sequence.
// - Receive end copies frame stamp to beacon stamp for matching valid beacons.
// - Beacon stamp holds until a new beacon or manual capture.
// - Manual capture bit stores the current counter in the beacon stamp.
// - Absolute compare matches when counter equals the compare value.
// - Relative compare matches when counter equals compare plus beacon stamp.
// - Events always set flags; only unmasked flags raise the interrupt.
// - The manual capture bit returns to zero by itself.
module stb_timestamp_unit #(
  parameter int SYMBOL_CYCLES = stb_pkg::SYMBOL_CYCLES
) (
  input  wire logic                 clock,
  input  wire logic                 arst_n,
  input  wire logic [31:0]          symbol_count_value,
  input  wire logic                 counterOverflow,
  input  wire logic                 stampEnable,
  input  wire stb_pkg::stb_rx_t     rxIn,
  input  wire logic [7:0]           network_id_low,
  input  wire logic [7:0]           network_id_high,
  input  wire stb_pkg::stb_cmp_t    compare_value_one,
  input  wire stb_pkg::stb_cmp_t    compare_value_two,
  input  wire stb_pkg::stb_cmp_t    compare_value_three,
  input  wire logic                 manual_beacon_capture_bit,
  input  wire logic                 syncRestart,
  input  wire logic                 trxClockRunning,
  input  wire logic                 trxAwake,
  input  wire logic [4:0]           counter_irq_mask,
  input  wire logic [4:0]           flagClearWrite,
  input  wire logic [4:0]           handlerEntered,
  output logic [4:0]                irqStatus,
  output logic                      irqRequest,
  output logic                      wakeRequest,
  output logic [31:0]               frameStamp,
  output logic [31:0]               beacon_stamp_reg,
  output logic                      manualCapturePending
);
  // The backoff divider is sixteen bits wide, so longer symbols cannot be served.
  initial begin
    if (SYMBOL_CYCLES < 1 || SYMBOL_CYCLES > 65535) begin
      $error("stb_timestamp_unit: SYMBOL_CYCLES out of range");
    end
  end

  // Inputs from the radio clock domain pass two flops before use.
  // The frame fields are levels held steady around the frame end strobe,
  // so they ride the same two flops and line up with the synchronised strobe.
  typedef struct packed {
    logic [1:0] sfd1;
    logic [1:0] end1;
    logic [1:0] clk1;
    logic [1:0] awk1;
    logic [1:0] fcs1;
    logic [1:0] bcn1;
    logic [1:0][15:0] src1;
    logic       sfdLast;
    logic       endLast;
    logic [4:0] flags;
    logic       irq;
    logic       wake;
    logic [31:0] frame;
    logic [31:0] beacon;
    logic       manual;
  } stb_state_t;

  stb_state_t state;
  stb_state_t next_state;
  logic       slotPulse;
  logic [4:0] events;
  logic       sfdRise;
  logic       endRise;
  logic       idMatch;
  logic       beaconCopy;

  // Compare match for one unit, absolute or relative to the beacon stamp.
  // The relative sum wraps at thirty-two bits, just as the symbol counter does.
  function automatic logic cmp_hit(input stb_pkg::stb_cmp_t c, input logic [31:0] cnt, input logic [31:0] base);
    logic [31:0] target;
    target = c.relative ? 32'(c.value + base) : c.value;
    return cnt == target;
  endfunction : cmp_hit

  // The slot counter runs only with the transceiver clock up and the radio awake.
  stb_backoff #(
    .SYMBOL_CYCLES (SYMBOL_CYCLES),
    .SLOT_SYMBOLS  (stb_pkg::SLOT_SYMBOLS)
  ) u_backoff (
    .clock     (clock),
    .arst_n    (arst_n),
    .enable    (state.clk1[1] & state.awk1[1]),
    .restart   (syncRestart),
    .slotPulse (slotPulse)
  );

  // Event detection from the synchronised strobes and the compare units.
  always_comb begin
    sfdRise = state.sfd1[1] & ~state.sfdLast;
    endRise = state.end1[1] & ~state.endLast;
    idMatch = (state.src1[1] == {network_id_high, network_id_low}) ||
              ({network_id_high, network_id_low} == stb_pkg::NETWORK_ID_ANY);
    // Only an intact beacon from the expected network is copied into the beacon stamp.
    beaconCopy = stampEnable && endRise && state.bcn1[1] && state.fcs1[1] && idMatch;
    // Compare events are levels; a frozen counter keeps a unit matching every cycle.
    events = 5'h00;
    events[stb_pkg::IRQ_CMP1]     = cmp_hit(compare_value_one, symbol_count_value, state.beacon);
    events[stb_pkg::IRQ_CMP2]     = cmp_hit(compare_value_two, symbol_count_value, state.beacon);
    events[stb_pkg::IRQ_CMP3]     = cmp_hit(compare_value_three, symbol_count_value, state.beacon);
    events[stb_pkg::IRQ_OVERFLOW] = counterOverflow;
    events[stb_pkg::IRQ_BACKOFF]  = slotPulse;
  end

  // Next state: flags with set winning over clear, stamps and capture bit.
  always_comb begin
    next_state = state;
    next_state.sfd1 = {state.sfd1[0], rxIn.sfdDone};
    next_state.end1 = {state.end1[0], rxIn.frameEnd};
    next_state.clk1 = {state.clk1[0], trxClockRunning};
    next_state.awk1 = {state.awk1[0], trxAwake};
    next_state.sfdLast = state.sfd1[1];
    next_state.endLast = state.end1[1];
    // Level fields of the frame pass the same two flops as the frame end strobe.
    next_state.fcs1 = {state.fcs1[0], rxIn.fcsValid};
    next_state.bcn1 = {state.bcn1[0], rxIn.isBeacon};
    next_state.src1 = {state.src1[0], rxIn.srcNetworkId};
    // A set in the same cycle as a clear keeps the flag, so no event is lost.
    next_state.flags = (state.flags & ~(flagClearWrite | handlerEntered)) | events;
    next_state.irq = |(next_state.flags & counter_irq_mask);
    next_state.wake = |events;
    // Stamp on every delimiter while stamping is enabled, checks on the frame body do not gate it.
    if (stampEnable && sfdRise) begin
      next_state.frame = symbol_count_value;
    end
    if (beaconCopy) begin
      next_state.beacon = state.frame;
    end
    // Manual capture takes precedence; the bit self-clears after one use.
    next_state.manual = 1'b0;
    if (manual_beacon_capture_bit) begin
      next_state.beacon = symbol_count_value;
    end
  end

  // One register holds all state apart from the backoff counter; reset clears every flag, stamp and synchroniser.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // Outputs come straight from the state register, so they never glitch.
  assign irqStatus            = state.flags;
  assign irqRequest           = state.irq;
  assign wakeRequest          = state.wake;
  assign frameStamp           = state.frame;
  assign beacon_stamp_reg     = state.beacon;
  assign manualCapturePending = state.manual;

  // Flags: set wins, clears land one cycle later, and the mask gates only the request.
  a_flag_set_wins: assert property (@(posedge clock) disable iff (!arst_n)
    events[0] |=> irqStatus[0]) else $error("compare one event lost");
  a_flag_clear: assert property (@(posedge clock) disable iff (!arst_n)
    (flagClearWrite[3] && !events[3]) |=> !irqStatus[3]) else $error("overflow flag not cleared");
  a_handler_clear: assert property (@(posedge clock) disable iff (!arst_n)
    (handlerEntered[1] && !events[1]) |=> !irqStatus[1]) else $error("handler did not clear flag");
  a_wake_event: assert property (@(posedge clock) disable iff (!arst_n)
    (|events) |=> wakeRequest) else $error("no wake on event");
  a_wake_quiet: assert property (@(posedge clock) disable iff (!arst_n)
    !(|events) |=> !wakeRequest) else $error("wake without event");
  a_irq_masked: assert property (@(posedge clock) disable iff (!arst_n)
    irqRequest |-> |(irqStatus & counter_irq_mask)) else $error("interrupt without unmasked flag");
  a_irq_unmasked: assert property (@(posedge clock) disable iff (!arst_n)
    (|(irqStatus & counter_irq_mask) && $stable(counter_irq_mask)) |-> irqRequest) else $error("unmasked flag silent");
  a_flag_sticky: assert property (@(posedge clock) disable iff (!arst_n)
    (irqStatus[2] && !flagClearWrite[2] && !handlerEntered[2]) |=> irqStatus[2]) else $error("flag lost");
  a_no_false_flag: assert property (@(posedge clock) disable iff (!arst_n)
    (!irqStatus[3] && !events[3]) |=> !irqStatus[3]) else $error("flag without event");
  a_backoff_flag: assert property (@(posedge clock) disable iff (!arst_n)
    slotPulse |=> irqStatus[4]) else $error("backoff flag missing");

  // Compare units, worked out here apart from the shared match function.
  a_compare_abs: assert property (@(posedge clock) disable iff (!arst_n)
    (!compare_value_three.relative && symbol_count_value == compare_value_three.value) |=> irqStatus[2])
    else $error("absolute match missed");
  a_compare_rel: assert property (@(posedge clock) disable iff (!arst_n)
    (compare_value_two.relative && symbol_count_value == 32'(compare_value_two.value + beacon_stamp_reg))
    |=> irqStatus[1]) else $error("relative match missed");

  // Stamps move only at their own strobes or at a manual capture.
  a_manual_capture: assert property (@(posedge clock) disable iff (!arst_n)
    manual_beacon_capture_bit |=> beacon_stamp_reg == $past(symbol_count_value)) else $error("manual capture wrong");
  a_frame_stamp: assert property (@(posedge clock) disable iff (!arst_n)
    (stampEnable && sfdRise) |=> frameStamp == $past(symbol_count_value)) else $error("frame stamp wrong");
  a_frame_hold: assert property (@(posedge clock) disable iff (!arst_n)
    !(stampEnable && sfdRise) |=> $stable(frameStamp)) else $error("frame stamp moved");
  a_beacon_hold: assert property (@(posedge clock) disable iff (!arst_n)
    (!manual_beacon_capture_bit && !endRise) |=> $stable(beacon_stamp_reg)) else $error("beacon stamp moved");
  a_beacon_copy: assert property (@(posedge clock) disable iff (!arst_n)
    (beaconCopy && !manual_beacon_capture_bit) |=> beacon_stamp_reg == $past(frameStamp)) else $error("copy wrong");
  a_beacon_refused: assert property (@(posedge clock) disable iff (!arst_n)
    (!beaconCopy && !manual_beacon_capture_bit) |=> $stable(beacon_stamp_reg)) else $error("copy not refused");
  a_stamp_off: assert property (@(posedge clock) disable iff (!arst_n)
    (!stampEnable && !manual_beacon_capture_bit) |=> $stable(beacon_stamp_reg)) else $error("copy while off");
  a_capture_clears: assert property (@(posedge clock) disable iff (!arst_n)
    manual_beacon_capture_bit |=> !manualCapturePending) else $error("capture bit stuck");

  // Main scenarios that the bench is expected to reach.
  c_beacon_copy: cover property (@(posedge clock) disable iff (!arst_n) beaconCopy);
  c_manual_capture: cover property (@(posedge clock) disable iff (!arst_n) manual_beacon_capture_bit);
  c_relative_hit: cover property (@(posedge clock) disable iff (!arst_n) compare_value_two.relative && events[1]);
  c_backoff_slot: cover property (@(posedge clock) disable iff (!arst_n) slotPulse);
  c_set_and_clear: cover property (@(posedge clock) disable iff (!arst_n) events[4] && flagClearWrite[4]);
endmodule : stb_timestamp_unit

// >>> verification/stb_rx_model.sv
// Behavioural radio receive path that delivers one frame per request.
`timescale 1ns/1ns
module stb_rx_model (
  input  wire logic        clock,
  input  wire logic        go,
  input  wire logic        beacon,
  input  wire logic        fcsOk,
  input  wire logic [15:0] srcId,
  output stb_pkg::stb_rx_t rxOut,
  output logic             busy
);
  // Fields hold from the delimiter until well past receive end, then show inverted junk.
  initial begin
    rxOut = '0;
    busy = 1'b0;
    forever begin
      @(posedge clock);
      if (go) begin
        busy <= 1'b1;
        rxOut <= '{1'b1, 1'b0, fcsOk, beacon, srcId};
        repeat (8) @(posedge clock);
        rxOut.frameEnd <= 1'b1;
        repeat (6) @(posedge clock);
        rxOut <= '{1'b0, 1'b0, ~fcsOk, ~beacon, ~srcId};
        busy <= 1'b0;
      end
    end
  end
endmodule : stb_rx_model

// >>> verification/test_symbol_timestamp_backoff_unit.sv
// Self-checking bench for the symbol timestamp and backoff unit.
`timescale 1ns/1ns
module test_symbol_timestamp_backoff_unit;
  logic clock, arst_n, counting, overflow, stampEn, manualBit, syncRestart, trxClk, trxAwake;
  logic go, beacon, fcsOk, busy, irqRequest, wakeRequest, pending;
  logic [31:0] count, frameStamp, beaconStamp, expF, expB;
  logic [15:0] netId, srcId;
  logic [4:0] mask, clearWr, handler, irqStatus;
  stb_pkg::stb_rx_t rxIn;
  stb_pkg::stb_cmp_t cmp [3];
  int fails, totalChecks, cycles;

  stb_rx_model rxModel (.clock(clock), .go(go), .beacon(beacon), .fcsOk(fcsOk), .srcId(srcId), .rxOut(rxIn),
    .busy(busy));
  stb_timestamp_unit #(.SYMBOL_CYCLES(2)) uut (.clock(clock), .arst_n(arst_n), .symbol_count_value(count),
    .counterOverflow(overflow), .stampEnable(stampEn), .rxIn(rxIn), .network_id_low(netId[7:0]),
    .network_id_high(netId[15:8]), .compare_value_one(cmp[0]), .compare_value_two(cmp[1]),
    .compare_value_three(cmp[2]), .manual_beacon_capture_bit(manualBit), .syncRestart(syncRestart),
    .trxClockRunning(trxClk), .trxAwake(trxAwake), .counter_irq_mask(mask), .flagClearWrite(clearWr),
    .handlerEntered(handler), .irqStatus(irqStatus), .irqRequest(irqRequest), .wakeRequest(wakeRequest),
    .frameStamp(frameStamp), .beacon_stamp_reg(beaconStamp), .manualCapturePending(pending));

  // Clock of 100 ns period.
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // The symbol count runs one step a cycle unless frozen; a hang is cut short after 5000 cycles.
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (counting) count <= count + 32'h1;
    if (cycles == 5000) begin
      fails++;
      finishTest();
    end
  end

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    totalChecks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic waitFlag(input int i, input int limit);
    @(negedge clock);
    for (int n = 0; n < limit && irqStatus[i] !== 1'b1; n++) @(negedge clock);
  endtask : waitFlag

  task automatic pulse(input logic [4:0] clr, input logic [4:0] hnd);
    @(posedge clock);
    clearWr <= clr;
    handler <= hnd;
    @(posedge clock);
    clearWr <= 5'h00;
    handler <= 5'h00;
    @(negedge clock);
  endtask : pulse

  // Manual capture stores the frozen count and the request bit reads back zero.
  task automatic testManual();
    @(posedge clock);
    counting <= 1'b0;
    count <= 32'h0001_2340;
    @(posedge clock);
    manualBit <= 1'b1;
    @(posedge clock);
    manualBit <= 1'b0;
    counting <= 1'b1;
    @(negedge clock);
    check("beacon stamp", 32'h0001_2340, beaconStamp);
    check("capture bit", 32'h0, pending);
  endtask : testManual

  // Unit two runs relative to the beacon stamp; flags pile up and are cleared one way or the other.
  task automatic testCompare();
    logic [31:0] target;
    logic [4:0] expS;
    expS = 5'h00;
    for (int i = 0; i < 3; i++) begin
      @(posedge clock);
      target = count + 32'h14;
      // Unit two gets an offset from the manual beacon stamp, placed ahead of the wanted moment.
      cmp[i] <= '{(i == 1), (i == 1) ? target - 32'h0001_2340 : target};
      waitFlag(i, 40);
      expS[i] = 1'b1;
      check("count after match", target + 32'h1, count);
      check("flags", expS, irqStatus);
      check("wake", 32'h1, wakeRequest);
      check("irq", |(expS & mask), irqRequest);
      @(negedge clock);
      check("wake drop", 32'h0, wakeRequest);
    end
    @(posedge clock);
    overflow <= 1'b1;
    for (int i = 0; i < 3; i++) cmp[i] <= '{1'b0, 32'hFFFF_0000};
    @(posedge clock);
    overflow <= 1'b0;
    @(negedge clock);
    check("overflow flags", 32'h0F, irqStatus);
    check("overflow wake", 32'h1, wakeRequest);
    pulse(5'h01, 5'h00);
    check("clear one", 32'h0E, irqStatus);
    pulse(5'h00, 5'h02);
    check("handler clear", 32'h0C, irqStatus);
    pulse(5'h04, 5'h00);
    check("masked only", 32'h08, {irqRequest, irqStatus});
    pulse(5'h08, 5'h00);
    check("all clear", 32'h0, {irqRequest, irqStatus});
  endtask : testCompare

  // Frame table: bad check sequence, match, mismatch, any id, not a beacon, stamping off.
  task automatic testFrames();
    logic [5:0] bV, fV, mV, aV, eV, uV;
    bV = 6'h2F;
    fV = 6'h3E;
    mV = 6'h0C;
    aV = 6'h08;
    eV = 6'h1F;
    uV = 6'h0A;
    counting <= 1'b0;
    for (int k = 0; k < 6; k++) begin
      @(posedge clock);
      count <= 32'h0002_0000 + 32'(k) * 32'h100;
      netId <= aV[k] ? 16'hFFFF : 16'h1234;
      srcId <= mV[k] ? 16'h4321 : 16'h1234;
      beacon <= bV[k];
      fcsOk <= fV[k];
      stampEn <= eV[k];
      go <= 1'b1;
      @(posedge clock);
      go <= 1'b0;
      repeat (2) @(negedge clock);
      for (int n = 0; n < 30 && busy !== 1'b0; n++) @(negedge clock);
      repeat (2) @(negedge clock);
      if (eV[k]) expF = 32'h0002_0000 + 32'(k) * 32'h100;
      if (uV[k]) expB = expF;
      check("frame stamp", expF, frameStamp);
      check("beacon copy", expB, beaconStamp);
    end
  endtask : testFrames

  // Backoff slots every 20 symbols of 2 cycles, silent when asleep or without the transceiver clock.
  task automatic testBackoff();
    realtime t0;
    @(posedge clock);
    trxClk <= 1'b1;
    trxAwake <= 1'b1;
    syncRestart <= 1'b1;
    @(posedge clock);
    syncRestart <= 1'b0;
    waitFlag(4, 60);
    t0 = $realtime;
    check("slot irq", 32'h1, irqRequest);
    pulse(5'h10, 5'h00);
    waitFlag(4, 60);
    check("slot cycles", 32'h28, 32'(int'(($realtime - t0) / 100)));
    // Restart mid-slot: seen one edge late, then twenty symbols, then the flag one cycle after the pulse.
    pulse(5'h10, 5'h00);
    @(posedge clock);
    syncRestart <= 1'b1;
    @(negedge clock);
    t0 = $realtime;
    @(posedge clock);
    syncRestart <= 1'b0;
    waitFlag(4, 60);
    check("restart cycles", 32'h2A, 32'(int'(($realtime - t0) / 100)));
    for (int j = 0; j < 2; j++) begin
      @(posedge clock);
      trxAwake <= j[0];
      trxClk <= ~j[0];
      repeat (4) @(posedge clock);
      pulse(5'h10, 5'h00);
      repeat (100) @(negedge clock);
      check("slot stopped", 32'h0, irqStatus);
    end
  endtask : testBackoff

  task automatic finishTest();
    if (fails == 0 && totalChecks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finishTest

  // Reset, then every scenario in turn.
  initial begin
    {arst_n, counting, overflow, manualBit, syncRestart, trxClk, trxAwake, go, beacon, fcsOk} = '0;
    {fails, totalChecks, cycles} = '0;
    {count, expF, clearWr, handler, srcId} = '0;
    expB = 32'h0001_2340;
    stampEn = 1'b1;
    netId = 16'h1234;
    mask = 5'h15;
    for (int i = 0; i < 3; i++) cmp[i] = '{1'b0, 32'hFFFF_0000};
    repeat (8) @(posedge clock);
    arst_n <= 1'b1;
    @(negedge clock);
    check("reset outputs", 32'h0, {irqStatus, irqRequest, wakeRequest, pending, frameStamp[7:0]});
    testManual();
    testCompare();
    testFrames();
    testBackoff();
    finishTest();
  end
endmodule : test_symbol_timestamp_backoff_unit
